// [verilog/frs_pkg.sv]
package frs_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ            = 25_000_000;
    localparam int unsigned DRIVE_HZ          = 1_000;
    localparam int unsigned DRIVE_HALF_CYC    = CLK_HZ / (2 * DRIVE_HZ);
    localparam int unsigned PICKUP_MS_DEF     = 2;
    localparam int unsigned LOSS_MS_DEF       = 4;
    localparam int unsigned CYC_PER_MS        = CLK_HZ / 1000;
    localparam int unsigned MONITOR_LIMIT_DEF = 2 * DRIVE_HALF_CYC + 16;

    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int unsigned GAIN_W      = 8;
    localparam int unsigned COUNT_W     = 16;
    localparam int unsigned TIME_W      = 16;
    localparam logic [GAIN_W-1:0] GAIN_RST = 8'h32;

    typedef struct packed {
        logic              flame_on;
        logic              fault;
        logic [COUNT_W-1:0] raw_count;
    } frs_sense_t;

    typedef struct packed {
        logic              wr;
        logic [TIME_W-1:0] pickup_ms;
        logic [TIME_W-1:0] flame_loss_response_time;
        logic [GAIN_W-1:0] gain;
    } frs_cfg_t;

    typedef enum logic [1:0] {
        FRS_OFF,
        FRS_PICKUP,
        FRS_ON,
        FRS_LOSING
    } frs_state_t;

endpackage : frs_pkg

// [verilog/frs_toggle_drive.sv]
`timescale 1ns/10ps
module frs_toggle_drive #(
    parameter int unsigned HALF_CYC = 12_500
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic enable,
    output logic      drive
);
    import frs_pkg::*;

    logic [$clog2(HALF_CYC+1)-1:0] cnt;

    // Enabled: square wave at 50 percent duty; disabled: held low.
    always_ff @(posedge clk) begin
        if (!reset_n || !enable) begin
            cnt   <= '0;
            drive <= 1'b0;
        end else if (cnt == ($bits(cnt))'(HALF_CYC - 1)) begin
            cnt   <= '0;
            drive <= ~drive;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

endmodule : frs_toggle_drive

// [verilog/frs_flame_relay.sv]
`timescale 1ns/10ps
module frs_flame_relay
    import frs_pkg::*;
#(
    parameter int unsigned PICKUP_MS     = PICKUP_MS_DEF,
    parameter int unsigned LOSS_MS       = LOSS_MS_DEF,
    parameter int unsigned MONITOR_LIMIT = MONITOR_LIMIT_DEF,
    parameter int unsigned MS_CYC        = CYC_PER_MS,
    parameter int unsigned HALF_CYC      = DRIVE_HALF_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire frs_pkg::frs_sense_t    sense,
    input  wire frs_pkg::frs_cfg_t      cfg,
    input  wire logic [frs_pkg::TIME_W-1:0] nv_pickup_ms,
    input  wire logic [frs_pkg::TIME_W-1:0] nv_loss_ms,
    input  wire logic [frs_pkg::GAIN_W-1:0] nv_gain,
    input  wire logic                   nv_valid,
    output logic                        nv_wr,
    output logic [frs_pkg::TIME_W-1:0]  nv_wr_pickup_ms,
    output logic [frs_pkg::TIME_W-1:0]  nv_wr_loss_ms,
    output logic [frs_pkg::GAIN_W-1:0]  nv_wr_gain,
    output logic [31:0]                 flame_count,
    output logic                        flame_drive,
    output logic                        check_drive,
    output logic                        fault_out,
    output logic                        flame_state
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [1:0] flame_sync;
    logic [1:0] fault_sync;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flame_sync <= 2'h0;
            fault_sync <= 2'h3;
        end else begin
            flame_sync <= {flame_sync[0], sense.flame_on};
            fault_sync <= {fault_sync[0], sense.fault};
        end
    end

    wire logic flame_s = flame_sync[1];
    wire logic fault_s = fault_sync[1];

    // ****************************************************************
    // Settings held in nonvolatile storage
    // ****************************************************************
    // Live copies are reloaded from storage after every power-up, so a
    // setting written before power loss is what runs afterwards.
    logic [TIME_W-1:0] pickup_ms;
    logic [TIME_W-1:0] loss_ms;
    logic [GAIN_W-1:0] gain;
    logic              loaded;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pickup_ms <= TIME_W'(PICKUP_MS);
            loss_ms   <= TIME_W'(LOSS_MS);
            gain      <= GAIN_RST;
            loaded    <= 1'b0;
        end else if (!loaded && nv_valid) begin
            pickup_ms <= nv_pickup_ms;
            loss_ms   <= nv_loss_ms;
            gain      <= nv_gain;
            loaded    <= 1'b1;
        end else if (cfg.wr) begin
            pickup_ms <= cfg.pickup_ms;
            loss_ms   <= cfg.flame_loss_response_time;
            gain      <= cfg.gain;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            nv_wr           <= 1'b0;
            nv_wr_pickup_ms <= '0;
            nv_wr_loss_ms   <= '0;
            nv_wr_gain      <= '0;
        end else begin
            nv_wr           <= cfg.wr;
            nv_wr_pickup_ms <= cfg.pickup_ms;
            nv_wr_loss_ms   <= cfg.flame_loss_response_time;
            nv_wr_gain      <= cfg.gain;
        end
    end

    // ****************************************************************
    // Flame count scaled by gain
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flame_count <= '0;
        end else begin
            flame_count <= 32'(sense.raw_count) * 32'(gain);
        end
    end

    // ****************************************************************
    // Millisecond tick and timers
    // ****************************************************************
    logic [$clog2(MS_CYC+1)-1:0] ms_cnt;
    logic                        ms_tick;
    logic [TIME_W-1:0]           ms_elapsed;
    frs_state_t                  state;
    logic                        fault;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ms_cnt  <= '0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (ms_cnt == ($bits(ms_cnt))'(MS_CYC - 1));
            ms_cnt  <= (ms_cnt == ($bits(ms_cnt))'(MS_CYC - 1)) ? '0 : ms_cnt + 1'b1;
        end
    end

    // ****************************************************************
    // Flame relay state machine
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state      <= FRS_OFF;
            ms_elapsed <= '0;
        end else if (fault) begin
            state      <= FRS_OFF;
            ms_elapsed <= '0;
        end else begin
            unique case (state)
                FRS_OFF: begin
                    ms_elapsed <= '0;
                    if (flame_s) state <= FRS_PICKUP;
                end
                FRS_PICKUP: begin
                    if (!flame_s) begin
                        state      <= FRS_OFF;
                        ms_elapsed <= '0;
                    end else if (ms_elapsed > pickup_ms) begin
                        state      <= FRS_ON;
                        ms_elapsed <= '0;
                    end else if (ms_tick) begin
                        ms_elapsed <= ms_elapsed + 1'b1;
                    end
                end
                FRS_ON: begin
                    ms_elapsed <= '0;
                    if (!flame_s) state <= FRS_LOSING;
                end
                FRS_LOSING: begin
                    if (flame_s) begin
                        state      <= FRS_ON;
                        ms_elapsed <= '0;
                    end else if (ms_elapsed >= loss_ms) begin
                        state      <= FRS_OFF;
                        ms_elapsed <= '0;
                    end else if (ms_tick) begin
                        ms_elapsed <= ms_elapsed + 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Relay drives and activity monitor
    // ****************************************************************
    logic check_en;
    logic flame_en;
    logic check_wave;
    logic flame_wave;

    assign check_en = loaded && !fault;
    assign flame_en = check_en && (state == FRS_ON || state == FRS_LOSING);

    frs_toggle_drive #(.HALF_CYC(HALF_CYC)) u_check (
        .clk     (clk),
        .reset_n (reset_n),
        .enable  (check_en),
        .drive   (check_wave)
    );

    frs_toggle_drive #(.HALF_CYC(HALF_CYC)) u_flame (
        .clk     (clk),
        .reset_n (reset_n),
        .enable  (flame_en),
        .drive   (flame_wave)
    );

    // The flame wave only passes while check_en is set, so a stuck check
    // drive, once the monitor latches a fault, also holds the flame drive low.
    assign check_drive = check_wave;
    assign flame_drive = flame_wave & check_en;

    // Watch each enabled wave; a stall latches a fault until reset, since
    // a stuck driver is not trusted to recover on its own.
    logic [$clog2(MONITOR_LIMIT+1)-1:0] idle_chk;
    logic [$clog2(MONITOR_LIMIT+1)-1:0] idle_flm;
    logic                               chk_prev;
    logic                               flm_prev;
    logic                               stall;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            chk_prev <= 1'b0;
            flm_prev <= 1'b0;
            idle_chk <= '0;
            idle_flm <= '0;
            stall    <= 1'b0;
        end else begin
            chk_prev <= check_wave;
            flm_prev <= flame_wave;
            idle_chk <= (!check_en || check_wave != chk_prev) ? '0 : idle_chk + 1'b1;
            idle_flm <= (!flame_en || flame_wave != flm_prev) ? '0 : idle_flm + 1'b1;
            if (idle_chk >= ($bits(idle_chk))'(MONITOR_LIMIT) ||
                idle_flm >= ($bits(idle_flm))'(MONITOR_LIMIT)) begin
                stall <= 1'b1;
            end
        end
    end

    assign fault       = fault_s || stall;
    assign fault_out   = fault;
    assign flame_state = (state == FRS_ON || state == FRS_LOSING);

endmodule : frs_flame_relay

// [test/frs_flame_relay_properties.sv]
`timescale 1ns/10ps
module frs_flame_relay_properties
    import frs_pkg::*;
#(
    parameter int unsigned HALF_CYC = DRIVE_HALF_CYC
) (
    input wire logic                        clk,
    input wire logic                        reset_n,
    input wire frs_pkg::frs_cfg_t           cfg,
    input wire logic                        nv_wr,
    input wire logic [frs_pkg::GAIN_W-1:0]  nv_wr_gain,
    input wire logic                        flame_drive,
    input wire logic                        check_drive,
    input wire logic                        fault_out,
    input wire logic                        flame_state
);
    // ****************************************************************
    // High run lengths; a run past half a period is a static level.
    // ****************************************************************
    logic [15:0] flm_run;
    logic [15:0] chk_run;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flm_run <= 16'h0;
            chk_run <= 16'h0;
        end else begin
            flm_run <= flame_drive ? flm_run + 16'h1 : 16'h0;
            chk_run <= check_drive ? chk_run + 16'h1 : 16'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence fault_held;
        fault_out [*4];
    endsequence
    drive_reset_a: assert property (disable iff (1'b0)
        !reset_n |=> !flame_drive && !check_drive) else $error("drive after reset");
    fault_flame_a: assert property (fault_held |-> !flame_drive)
        else $error("flame drive under fault");
    fault_check_a: assert property (fault_held |-> !check_drive)
        else $error("check drive under fault");
    flame_state_a: assert property (
        flame_drive |-> flame_state || $past(flame_state)) else $error("drive without flame");
    flame_static_a: assert property (flame_drive |-> flm_run < HALF_CYC)
        else $error("flame drive static");
    check_static_a: assert property (check_drive |-> chk_run < HALF_CYC)
        else $error("check drive static");
    check_period_a: assert property (disable iff (!reset_n || fault_out)
        $fell(check_drive) |-> chk_run == HALF_CYC) else $error("check half period");
    nv_store_a: assert property (
        nv_wr |-> $past(cfg.wr) && nv_wr_gain == $past(cfg.gain)) else $error("store");
    flame_gate_a: assert property (flame_drive |-> !fault_out)
        else $error("flame drive without check");
endmodule : frs_flame_relay_properties
bind frs_flame_relay frs_flame_relay_properties #(.HALF_CYC(HALF_CYC)) u_props (
    .clk(clk), .reset_n(reset_n), .cfg(cfg), .nv_wr(nv_wr), .nv_wr_gain(nv_wr_gain),
    .flame_drive(flame_drive), .check_drive(check_drive), .fault_out(fault_out),
    .flame_state(flame_state));

// [test/frs_relay_coil.sv]
`timescale 1ns/10ps
module frs_relay_coil #(
    parameter int unsigned HALF_CYC = 4
) (
    input  wire logic clk,
    input  wire logic drive,
    output logic      energized
);
    // ****************************************************************
    // Coil pulls in on a wave of the right period or faster; a slow wave drops.
    // ****************************************************************
    int unsigned since = 0;
    int unsigned edges = 0;
    logic        last  = 1'b0;
    always_ff @(posedge clk) begin
        last <= drive;
        if (drive != last) begin
            since <= 0;
            edges <= (edges < 3) ? edges + 1 : 3;
        end else if (since < HALF_CYC) begin
            since <= since + 1;
        end else begin
            edges <= 0;
        end
    end
    assign energized = (edges >= 2) && (since < HALF_CYC);
endmodule : frs_relay_coil

// [test/frs_flame_relay_tb.sv]
`timescale 1ns/10ps
module frs_flame_relay_tb;
    import frs_pkg::*;
    localparam int unsigned MS = 10;
    localparam int unsigned HC = 4;
    logic               clk, reset_n, nv_valid, nv_wr, flame_drive, check_drive;
    logic               fault_out, flame_state, flame_relay, check_relay;
    frs_sense_t         sense;
    frs_cfg_t           cfg;
    logic [TIME_W-1:0]  nv_p, nv_l, wr_p, wr_l;
    logic [GAIN_W-1:0]  nv_g, wr_g;
    logic [31:0]        flame_count;
    logic [31:0]        rng = 32'h8bfd5737;
    int                 err_total = 0;
    int                 comparisons = 0;
    int                 n;
    int                 g;
    int                 exp_q[$];
    frs_flame_relay #(.MS_CYC(MS), .HALF_CYC(HC), .MONITOR_LIMIT(2 * HC + 4)) dut (
        .clk(clk), .reset_n(reset_n), .sense(sense), .cfg(cfg), .nv_pickup_ms(nv_p),
        .nv_loss_ms(nv_l), .nv_gain(nv_g), .nv_valid(nv_valid), .nv_wr(nv_wr),
        .nv_wr_pickup_ms(wr_p), .nv_wr_loss_ms(wr_l), .nv_wr_gain(wr_g),
        .flame_count(flame_count), .flame_drive(flame_drive), .check_drive(check_drive),
        .fault_out(fault_out), .flame_state(flame_state));
    frs_relay_coil #(.HALF_CYC(HC)) u_flame (.clk(clk), .drive(flame_drive),
        .energized(flame_relay));
    frs_relay_coil #(.HALF_CYC(HC)) u_check (.clk(clk), .drive(check_drive),
        .energized(check_relay));
    // ****************************************************************
    // Helpers.
    // ****************************************************************
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic wait_state(input logic lvl);
        n = 0;
        while (flame_state !== lvl && n < 2000) begin
            cyc(1);
            n++;
        end
    endtask : wait_state
    task automatic powerup();
        reset_n = 1'b0;
        cyc(16);
        reset_n = 1'b1;
        cyc(6 * HC);
    endtask : powerup
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("ERROR watchdog expected done seen timeout");
        stop_test();
    end
    // ****************************************************************
    // Scenarios; the bench holds the nonvolatile copy of the settings.
    // ****************************************************************
    initial begin
        sense = '0;
        cfg = '0;
        nv_p = 16'h0002;
        nv_l = 16'h0003;
        nv_g = 8'h10;
        nv_valid = 1'b1;
        reset_n = 1'b0;
        #1;
        powerup();
        check("check relay", 1, check_relay);
        check("flame idle", 0, flame_relay);
        sense.flame_on = 1'b1;
        cyc(MS);
        sense.flame_on = 1'b0;
        cyc(4 * MS);
        check("short flame", 0, flame_state);
        sense.flame_on = 1'b1;
        wait_state(1'b1);
        check("pickup late", 1, n > 2 * MS);
        check("pickup bound", 1, n <= 3 * MS + 6);
        cyc(3 * HC);
        check("flame relay", 1, flame_relay);
        check("gate relay", 1, check_relay);
        sense.flame_on = 1'b0;
        wait_state(1'b0);
        check("loss late", 1, n >= 2 * MS);
        check("loss bound", 1, n <= 4 * MS + 6);
        cyc(2 * HC);
        check("flame off", 0, flame_relay);
        sense.flame_on = 1'b1;
        wait_state(1'b1);
        cyc(3 * HC);
        sense.fault = 1'b1;
        cyc(4);
        check("fault state", 0, flame_state);
        check("fault out", 1, fault_out);
        cyc(2 * HC);
        check("fault flame", 0, flame_relay);
        check("fault check", 0, check_relay);
        sense = '0;
        cfg.pickup_ms = nv_p;
        cfg.flame_loss_response_time = nv_l;
        for (int i = 0; i < 4; i++) begin
            g = 1 + int'(xs() % 99);
            sense.raw_count = 16'(xs());
            cfg.gain = 8'(g);
            cfg.wr = 1'b1;
            cyc(1);
            cfg.wr = 1'b0;
            check("store pulse", 1, nv_wr);
            check("store gain", g, wr_g);
            check("store pickup", cfg.pickup_ms, wr_p);
            check("store loss", cfg.flame_loss_response_time, wr_l);
            exp_q.push_back(int'(sense.raw_count) * g);
            cyc(4);
            check("count", exp_q.pop_front(), flame_count);
        end
        check("fault clear", 0, fault_out);
        nv_g = wr_g;
        powerup();
        check("count kept", int'(sense.raw_count) * g, flame_count);
        stop_test();
    end
endmodule : frs_flame_relay_tb
